/* File: pll_nco_clock_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_map.svh"

module pll_nco_clock_config (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_ce,
   input  wire pll_clock_pkg::reg_req_t     i_req,
   input  wire logic                        i_frontend_enable,
   input  wire logic                        i_pll_lock_raw,
   input  wire logic                        i_vco_tick,
   output logic [7:0]                       o_reg_rdata,
   output logic                             o_reg_rvalid,
   output logic                             o_pll_power_on,
   output logic                             o_xtal_clk_en,
   output logic                             o_vco_clk_en,
   output logic                             o_pll_ref_tick,
   output logic                             o_fb_tick,
   output logic                             o_pll_locked_flag,
   output pll_clock_pkg::analog_ctl_t       o_analog
);

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam logic [3:0]  DEAD_CNT   = 4'(`DEAD_CYC);
   localparam logic [11:0] SETTLE_CNT = 12'(`SETTLE_CYC);

   // switch states under short names, nothing is imported
   localparam pll_clock_pkg::sw_state_t SW_XTAL    = pll_clock_pkg::SW_XTAL;
   localparam pll_clock_pkg::sw_state_t SW_TO_VCO  = pll_clock_pkg::SW_TO_VCO;
   localparam pll_clock_pkg::sw_state_t SW_VCO     = pll_clock_pkg::SW_VCO;
   localparam pll_clock_pkg::sw_state_t SW_TO_XTAL = pll_clock_pkg::SW_TO_XTAL;

   localparam pll_clock_pkg::pll_cfg_t CFG_RST = '{
      pseq:  `RST_PRESCALER_PATTERN,
      prate: `RST_PRESCALER_RATE_DIVISOR,
      pump:  `RST_PUMP_AND_VCO_RANGE,
      ndiv:  `RST_LOOP_DIVISOR,
      nseq:  `RST_LOOP_PATTERN,
      bias:  `RST_OSC_BIAS_LOOP_RATE
   };

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      pll_clock_pkg::pll_cfg_t    shadow;
      pll_clock_pkg::pll_cfg_t    active;
      logic                       force_vco;
      logic                       pll_powerdown;
      pll_clock_pkg::sw_state_t   sw;
      logic [3:0]                 dead;
      logic [11:0]                settle;
      logic                       locked;
      pll_clock_pkg::nco_t        pre;
      pll_clock_pkg::nco_t        loop;
      logic                       pwr;
      logic                       xtal_en;
      logic                       vco_en;
      logic [7:0]                 rdata;
      logic                       rvalid;
      pll_clock_pkg::analog_ctl_t ana;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   // ----------------------------------------------------------------
   // nco divider step
   // ----------------------------------------------------------------
   // divides by dvsr, or dvsr+1 where the pattern bit of the current
   // sequence slot is set; the slot index restarts every rate outputs
   function automatic pll_clock_pkg::nco_t nco_step(
      input pll_clock_pkg::nco_t s,
      input logic [6:0]          dvsr,
      input logic [7:0]          pat,
      input logic [2:0]          rate,
      input logic                tick
   );
      pll_clock_pkg::nco_t n;
      logic [7:0]          lim;
      logic                use_pat;
      n       = s;
      n.out   = 1'b0;
      use_pat = (rate != 3'h0);
      lim     = {1'b0, dvsr} + ((use_pat && pat[s.idx]) ? 8'h01 : 8'h00);
      if (tick) begin
         if (8'(s.cnt + 8'h01) >= lim) begin
            n.cnt = 8'h00;
            n.out = 1'b1;
            if (!use_pat || s.idx >= 3'(rate - 3'h1)) begin
               n.idx = 3'h0;
            end else begin
               n.idx = 3'(s.idx + 3'h1);
            end
         end else begin
            n.cnt = 8'(s.cnt + 8'h01);
         end
      end
      return n;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic pll_on_req;
      logic apply;
      logic [7:0] wd;
      pll_on_req = 1'b0;
      apply      = 1'b0;
      wd         = i_req.wdata;
      nxt_state  = state_ff;
      nxt_state.rvalid = 1'b0;

      // register writes: pll settings into the shadow copy, 0eh bits directly
      if (i_req.wr) begin
         case (i_req.addr)
            `OFS_PRESCALER_PATTERN: begin
               nxt_state.shadow.pseq = wd;
            end
            `OFS_PRESCALER_RATE_DIVISOR: begin
               nxt_state.shadow.prate = wd;
            end
            `OFS_PUMP_AND_VCO_RANGE: begin
               nxt_state.shadow.pump = wd;
               nxt_state.shadow.pump[`PUMP_RSVD] = 1'b0;
            end
            `OFS_LOOP_DIVISOR: begin
               nxt_state.shadow.ndiv = {1'b0, wd[`NDVSR_MSB:`NDVSR_LSB]};
            end
            `OFS_LOOP_PATTERN: begin
               nxt_state.shadow.nseq = wd;
            end
            `OFS_OSC_BIAS_LOOP_RATE: begin
               nxt_state.shadow.bias = {wd[`BIAS_MSB:`BIAS_LSB], 3'h0,
                                        wd[`NRATE_MSB:`NRATE_LSB]};
               apply = 1'b1;
            end
            `OFS_PLL_CLOCK_POWER_LOCK: begin
               nxt_state.force_vco     = wd[`FRC_VCO_BIT];
               nxt_state.pll_powerdown = wd[`PWDN_BIT];
            end
            default: begin
            end
         endcase
      end

      // whole configuration takes effect together
      if (apply) begin
         nxt_state.active = nxt_state.shadow;
      end

      // force-vco is cleared while the pll may not run
      if (nxt_state.pll_powerdown || !i_frontend_enable) begin
         nxt_state.force_vco = 1'b0;
      end

      pll_on_req = i_frontend_enable && !nxt_state.pll_powerdown;

      // register reads
      if (i_req.rd) begin
         nxt_state.rvalid = 1'b1;
         case (i_req.addr)
            `OFS_PRESCALER_PATTERN:      nxt_state.rdata = state_ff.shadow.pseq;
            `OFS_PRESCALER_RATE_DIVISOR: nxt_state.rdata = state_ff.shadow.prate;
            `OFS_PUMP_AND_VCO_RANGE:     nxt_state.rdata = state_ff.shadow.pump;
            `OFS_LOOP_DIVISOR:           nxt_state.rdata = state_ff.shadow.ndiv;
            `OFS_LOOP_PATTERN:           nxt_state.rdata = state_ff.shadow.nseq;
            `OFS_OSC_BIAS_LOOP_RATE:     nxt_state.rdata = state_ff.shadow.bias;
            `OFS_PLL_CLOCK_POWER_LOCK: begin
               nxt_state.rdata = 8'h00;
               nxt_state.rdata[`FRC_VCO_BIT] = state_ff.force_vco;
               nxt_state.rdata[`PWDN_BIT]    = state_ff.pll_powerdown;
               nxt_state.rdata[`LOCK_BIT]    = state_ff.locked;
            end
            default: nxt_state.rdata = 8'h00;
         endcase
      end

      // break-before-make clock switch
      case (state_ff.sw)
         SW_XTAL: begin
            nxt_state.xtal_en = 1'b1;
            nxt_state.vco_en  = 1'b0;
            if (state_ff.force_vco && state_ff.pwr && state_ff.locked) begin
               nxt_state.xtal_en = 1'b0;
               nxt_state.dead    = DEAD_CNT;
               nxt_state.sw      = SW_TO_VCO;
            end
         end
         SW_TO_VCO: begin
            nxt_state.xtal_en = 1'b0;
            nxt_state.vco_en  = 1'b0;
            if (!state_ff.force_vco) begin
               nxt_state.dead = DEAD_CNT;
               nxt_state.sw   = SW_TO_XTAL;
            end else if (state_ff.dead <= 4'h1) begin
               nxt_state.vco_en = 1'b1;
               nxt_state.sw     = SW_VCO;
            end else begin
               nxt_state.dead = 4'(state_ff.dead - 4'h1);
            end
         end
         SW_VCO: begin
            nxt_state.xtal_en = 1'b0;
            nxt_state.vco_en  = 1'b1;
            if (!state_ff.force_vco) begin
               nxt_state.vco_en = 1'b0;
               nxt_state.dead   = DEAD_CNT;
               nxt_state.sw     = SW_TO_XTAL;
            end
         end
         SW_TO_XTAL: begin
            nxt_state.xtal_en = 1'b0;
            nxt_state.vco_en  = 1'b0;
            if (state_ff.dead <= 4'h1) begin
               nxt_state.xtal_en = 1'b1;
               nxt_state.sw      = SW_XTAL;
            end else begin
               nxt_state.dead = 4'(state_ff.dead - 4'h1);
            end
         end
         default: begin
            nxt_state.xtal_en = 1'b1;
            nxt_state.vco_en  = 1'b0;
            nxt_state.sw      = SW_XTAL;
         end
      endcase

      // power-off waits until the system clock is back on the crystal
      nxt_state.pwr = pll_on_req || (state_ff.sw != SW_XTAL) ||
                      nxt_state.vco_en;

      // lock qualification: restarts on power-off and on each apply
      if (!state_ff.pwr || !pll_on_req || apply || !i_pll_lock_raw) begin
         nxt_state.locked = 1'b0;
         nxt_state.settle = SETTLE_CNT;
      end else if (state_ff.settle != 12'h000) begin
         nxt_state.settle = 12'(state_ff.settle - 12'h001);
      end else begin
         nxt_state.locked = 1'b1;
      end

      // prescaler nco on the crystal clock makes the pll reference
      nxt_state.pre = nco_step(state_ff.pre,
                               {2'b00, state_ff.active.prate[`PDVSR_MSB:`PDVSR_LSB]},
                               state_ff.active.pseq,
                               state_ff.active.prate[`PRATE_MSB:`PRATE_LSB],
                               state_ff.pwr);
      // feedback nco counts vco ticks
      nxt_state.loop = nco_step(state_ff.loop,
                                state_ff.active.ndiv[`NDVSR_MSB:`NDVSR_LSB],
                                state_ff.active.nseq,
                                state_ff.active.bias[`NRATE_MSB:`NRATE_LSB],
                                state_ff.pwr && i_vco_tick);

      // analog trims from the applied copy
      nxt_state.ana.pump_current = state_ff.active.pump[`PUMP_MSB:`PUMP_LSB];
      nxt_state.ana.vco_range    = state_ff.active.pump[`VCO_MSB:`VCO_LSB];
      nxt_state.ana.osc_bias     = state_ff.active.bias[`BIAS_MSB:`BIAS_LSB];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff.shadow        <= CFG_RST;
         state_ff.active        <= CFG_RST;
         state_ff.force_vco     <= 1'b0;
         state_ff.pll_powerdown <= 1'b0;
         state_ff.sw            <= pll_clock_pkg::SW_XTAL;
         state_ff.dead          <= 4'h0;
         state_ff.settle        <= 12'h000;
         state_ff.locked        <= 1'b0;
         state_ff.pre           <= '0;
         state_ff.loop          <= '0;
         state_ff.pwr           <= 1'b0;
         state_ff.xtal_en       <= 1'b1;
         state_ff.vco_en        <= 1'b0;
         state_ff.rdata         <= 8'h00;
         state_ff.rvalid        <= 1'b0;
         state_ff.ana.pump_current <= 4'h2;
         state_ff.ana.vco_range    <= 3'h2;
         state_ff.ana.osc_bias     <= 2'h1;
      end else if (i_ce) begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_reg_rdata       = state_ff.rdata;
   assign o_reg_rvalid      = state_ff.rvalid;
   assign o_pll_power_on    = state_ff.pwr;
   assign o_xtal_clk_en     = state_ff.xtal_en;
   assign o_vco_clk_en      = state_ff.vco_en;
   assign o_pll_ref_tick    = state_ff.pre.out;
   assign o_fb_tick         = state_ff.loop.out;
   assign o_pll_locked_flag = state_ff.locked;
   assign o_analog          = state_ff.ana;

endmodule
`default_nettype wire

/* File: pll_clock_map.svh */
// What this block does
// - prescaler pattern ignored when restart rate zero
// - prescaler register: 3-bit rate, 5-bit divisor
// - 3-bit vco range code picks eight settings
// - 7-bit loop divisor, loop pattern ignored at zero rate
// - 8-bit loop pattern drives feedback nco
// - 2-bit oscillator bias selects crystal bias current
// - 3-bit loop restart rate in bias register
// - new pll settings apply on 0dh write
// - force-vco bit picks crystal or vco clock
// - force-vco cleared by reset, powerdown, frontend off
// - power-off held until clock back on crystal
// - read-only lock flag reports pll lock
// - pll powered with frontend on and no powerdown, and also held on until clock back on crystal
// - crystal clock passes nco prescaler to pll
// - frontend enable low after reset, crystal clock
`ifndef PLL_CLOCK_MAP_SVH
`define PLL_CLOCK_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PRESCALER_PATTERN      8'h08
`define OFS_PRESCALER_RATE_DIVISOR 8'h09
`define OFS_PUMP_AND_VCO_RANGE     8'h0a
`define OFS_LOOP_DIVISOR           8'h0b
`define OFS_LOOP_PATTERN           8'h0c
`define OFS_OSC_BIAS_LOOP_RATE     8'h0d
`define OFS_PLL_CLOCK_POWER_LOCK   8'h0e

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PRESCALER_PATTERN      8'h00
`define RST_PRESCALER_RATE_DIVISOR 8'h0a
`define RST_PUMP_AND_VCO_RANGE     8'h22
`define RST_LOOP_DIVISOR           8'h00
`define RST_LOOP_PATTERN           8'h00
`define RST_OSC_BIAS_LOOP_RATE     8'h48

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRATE_MSB    7
`define PRATE_LSB    5
`define PDVSR_MSB    4
`define PDVSR_LSB    0
`define PUMP_MSB     7
`define PUMP_LSB     4
`define PUMP_RSVD    3
`define VCO_MSB      2
`define VCO_LSB      0
`define NDVSR_MSB    6
`define NDVSR_LSB    0
`define BIAS_MSB     7
`define BIAS_LSB     6
`define NRATE_MSB    2
`define NRATE_LSB    0
`define FRC_VCO_BIT  7
`define PWDN_BIT     6
`define LOCK_BIT     5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define DEADTIME_NS   20
`define SETTLE_NS     10000
`define DEAD_CYC  ((`DEADTIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETTLE_CYC ((`SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* File: pll_clock_pkg.sv */
`default_nettype none
package pll_clock_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pseq;
      logic [7:0] prate;
      logic [7:0] pump;
      logic [7:0] ndiv;
      logic [7:0] nseq;
      logic [7:0] bias;
   } pll_cfg_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [2:0] idx;
      logic       out;
   } nco_t;

   typedef enum logic [1:0] {
      SW_XTAL,
      SW_TO_VCO,
      SW_VCO,
      SW_TO_XTAL
   } sw_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] pump_current;
      logic [2:0] vco_range;
      logic [1:0] osc_bias;
   } analog_ctl_t;

endpackage
`default_nettype wire

/* File: pll_clock_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pll_clock_sva (
   input wire logic                       i_clk,
   input wire logic                       i_rst_n,
   input wire logic                       i_ce,
   input wire pll_clock_pkg::reg_req_t    i_req,
   input wire logic                       i_frontend_enable,
   input wire logic                       i_pll_lock_raw,
   input wire logic                       i_vco_tick,
   input wire logic [7:0]                 o_reg_rdata,
   input wire logic                       o_reg_rvalid,
   input wire logic                       o_pll_power_on,
   input wire logic                       o_xtal_clk_en,
   input wire logic                       o_vco_clk_en,
   input wire logic                       o_pll_ref_tick,
   input wire logic                       o_fb_tick,
   input wire logic                       o_pll_locked_flag,
   input wire pll_clock_pkg::analog_ctl_t o_analog
);
   // ---------------------------------------------
   // stable lock counter
   // ---------------------------------------------
   localparam int LOCK_MIN = 1998;
   logic        wr_apply;
   logic [11:0] stable_ff;
   logic [11:0] nxt_stable;
   assign wr_apply = i_ce && i_req.wr && (i_req.addr == 8'h0d);
   always_comb begin
      nxt_stable = stable_ff;
      if (i_ce && (!i_pll_lock_raw || !o_pll_power_on || wr_apply)) begin
         nxt_stable = 12'h000;
      end else if (i_ce && stable_ff != 12'hfff) begin
         nxt_stable = stable_ff + 12'h001;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stable_ff <= 12'h000;
      end else begin
         stable_ff <= nxt_stable;
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence dead_gap;
      (!o_xtal_clk_en && !o_vco_clk_en) [*4];
   endsequence
   sequence xtal_off_idle;
      (i_ce && !i_frontend_enable && o_xtal_clk_en && !o_vco_clk_en) [*2];
   endsequence
   clk_exclusive_a: assert property (!(o_xtal_clk_en && o_vco_clk_en))
      else $error("both clock gates open");
   gap_to_vco_a: assert property ($fell(o_xtal_clk_en) |-> dead_gap)
      else $error("short gap before vco clock");
   gap_to_xtal_a: assert property ($fell(o_vco_clk_en) |-> dead_gap)
      else $error("short gap before crystal clock");
   vco_powered_a: assert property (o_vco_clk_en |-> o_pll_power_on)
      else $error("vco clock used while pll off");
   power_off_a: assert property (xtal_off_idle |=> !o_pll_power_on)
      else $error("pll powered with frontend off");
   lock_loss_a: assert property (i_ce && !i_pll_lock_raw |=> !o_pll_locked_flag)
      else $error("lock flag kept after raw loss");
   lock_apply_a: assert property (wr_apply |=> !o_pll_locked_flag)
      else $error("lock flag kept over reconfigure");
   lock_settle_a: assert property ($rose(o_pll_locked_flag) |-> stable_ff >= LOCK_MIN)
      else $error("lock reported before settling");
   read_answer_a: assert property (i_ce && i_req.rd |=> o_reg_rvalid)
      else $error("read not answered");
   read_quiet_a: assert property (i_ce && !i_req.rd |=> !o_reg_rvalid)
      else $error("read answer without request");
   unmapped_zero_a: assert property (i_ce && i_req.rd && (i_req.addr < 8'h08
      || i_req.addr > 8'h0e) |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   analog_apply_a: assert property ($changed(o_analog) |-> $past(wr_apply, 2))
      else $error("analog codes changed without apply");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                       i_clk = 1'b0;
   logic                       i_rst_n = 1'b0;
   logic                       ce = 1'b1;
   pll_clock_pkg::reg_req_t    req = '0;
   logic                       fe = 1'b0;
   logic                       lock_raw = 1'b0;
   logic                       vco_tick = 1'b1;
   logic [7:0]                 rdata;
   logic                       rvalid, pwr, xen, ven, rtick, ftick, locked;
   pll_clock_pkg::analog_ctl_t ana;
   int                         n_mismatch = 0;
   int                         cmp_count = 0;
   logic [7:0]                 got;
   always #2.5 i_clk = ~i_clk;
   pll_nco_clock_config dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_req(req),
      .i_frontend_enable(fe), .i_pll_lock_raw(lock_raw), .i_vco_tick(vco_tick),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_pll_power_on(pwr),
      .o_xtal_clk_en(xen), .o_vco_clk_en(ven), .o_pll_ref_tick(rtick), .o_fb_tick(ftick),
      .o_pll_locked_flag(locked), .o_analog(ana));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step(1);
      req.wr = 1'b1; req.addr = a; req.wdata = d;
      step(1);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      step(1);
      req.rd = 1'b1; req.addr = a;
      step(1);
      req.rd = 1'b0;
      chk("rvalid", 9'h001, {8'h00, rvalid});
      got = rdata;
   endtask
   task automatic gap(input bit fb, input int exp, input string nm);
      int n;
      n = 0;
      while (((fb ? ftick : rtick) !== 1'b1) && n < 200) begin step(1); n++; end
      n = 0;
      do begin step(1); n++; end while (((fb ? ftick : rtick) !== 1'b1) && n < 200);
      chk(nm, 9'(exp), 9'(n));
   endtask
   task automatic wait_lock();
      for (int n = 0; n < 2300 && locked !== 1'b1; n++) step(1);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      logic [7:0] tab [7];
      tab = '{8'h00, 8'h0a, 8'h22, 8'h00, 8'h00, 8'h48, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd(8'(8'h08 + i));
         chk("reset value", {1'b0, tab[i]}, {1'b0, got});
      end
      rd(8'h07); chk("unmapped", 9'h000, {1'b0, got});
      rd(8'hff); chk("unmapped", 9'h000, {1'b0, got});
      chk("analog reset", 9'h049, ana);
      chk("xtal gate", 9'h001, {8'h00, xen});
      chk("power", 9'h000, {8'h00, pwr});
   endtask
   task automatic t_masks();
      wr(8'h0a, 8'hf7); wr(8'h0b, 8'hff);
      rd(8'h0a); chk("pump reg", 9'h0f7, {1'b0, got});
      rd(8'h0b); chk("loop divisor", 9'h07f, {1'b0, got});
      chk("analog held", 9'h049, ana);
      wr(8'h0d, 8'hff); step(2);
      chk("analog applied", 9'h1ff, ana);
      rd(8'h0d); chk("bias reg", 9'h0c7, {1'b0, got});
      wr(8'h0e, 8'h20); rd(8'h0e); chk("lock read only", 9'h000, {1'b0, got});
      ce = 1'b0; wr(8'h08, 8'h55); ce = 1'b1;
      rd(8'h08); chk("frozen write", 9'h000, {1'b0, got});
   endtask
   task automatic t_power();
      fe = 1'b1; step(3);
      chk("power on", 9'h001, {8'h00, pwr});
      wr(8'h0e, 8'h40); step(3);
      chk("power down", 9'h000, {8'h00, pwr});
      wr(8'h0e, 8'h00); step(3);
      chk("power on", 9'h001, {8'h00, pwr});
   endtask
   task automatic t_nco();
      wr(8'h08, 8'hff); wr(8'h09, 8'h04); wr(8'h0a, 8'h22);
      wr(8'h0b, 8'h03); wr(8'h0c, 8'hff); wr(8'h0d, 8'h01);
      gap(1'b0, 4, "ref tick gap");
      gap(1'b1, 4, "fb tick gap");
      wr(8'h09, 8'h24); wr(8'h0d, 8'h01);
      gap(1'b0, 5, "ref pattern gap");
   endtask
   task automatic t_switch();
      lock_raw = 1'b1; wait_lock();
      chk("locked", 9'h001, {8'h00, locked});
      rd(8'h0e); chk("lock bit", 9'h020, {1'b0, got});
      wr(8'h0d, 8'h01); step(1);
      chk("lock restart", 9'h000, {8'h00, locked});
      wait_lock(); wr(8'h0e, 8'h80); step(2);
      chk("xtal off", 9'h000, {7'h00, xen, ven});
      step(4); chk("vco on", 9'h001, {8'h00, ven});
      rd(8'h0e); chk("force vco", 9'h0a0, {1'b0, got});
      fe = 1'b0; step(2);
      chk("power kept", 9'h001, {8'h00, pwr});
      step(8); chk("back on xtal", 9'h002, {7'h00, xen, ven});
      chk("power off", 9'h000, {8'h00, pwr});
      rd(8'h0e); chk("force cleared", 9'h000, {1'b0, got});
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      t_reset(); t_masks(); t_power(); t_nco(); t_switch();
      finish_test();
   end
   initial begin
      #(40000 * 5);
      n_mismatch++;
      finish_test();
   end
endmodule
bind pll_nco_clock_config pll_clock_sva chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
   .i_req(i_req), .i_frontend_enable(i_frontend_enable), .i_pll_lock_raw(i_pll_lock_raw),
   .i_vco_tick(i_vco_tick), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .o_pll_power_on(o_pll_power_on), .o_xtal_clk_en(o_xtal_clk_en),
   .o_vco_clk_en(o_vco_clk_en), .o_pll_ref_tick(o_pll_ref_tick), .o_fb_tick(o_fb_tick),
   .o_pll_locked_flag(o_pll_locked_flag), .o_analog(o_analog));
`default_nettype wire
